// *** light_reg.sv ***
// Constant-light regulator core with AXI4-Lite register access
`timescale 1ns/1ps
//
// Function
// - Four phases cycle: off, startup, regulate, step-down
// - Off phase keeps lighting switched off
// - Presence in off enters startup
// - Presence from block one or bus
// - Dark startup: switch on, wait, regulate
// - Bright startup: regulate at once, lights stay
// - Regulate dims to keep within band
// - Regulate may switch off, staying in phase
// - Dim output relative steps or absolute level
// - Presence lost in regulate enters step-down
// - Step-down: off directly or dim, wait, off
// - Standalone mode: external sender drives presence
// - Combined mode uses block one only
// - Change lighting only outside the band
// - Lower limit target, upper adds hysteresis
// - Target change recomputes upper limit
// - Target feedback sent on change, download, return
// - Target limited per dynamic profile range
// - External two-byte target adopted as target
// - External target persists until replaced
// - Download restores default only if overwriting
// - External writes accepted in any phase
// - Restore returns target to configured default
module light_reg (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic fb1_presence,
	input wire logic [15:0] fb1_brightness,
	output light_reg_pkg::dim_cmd_type dim_out,
	output light_reg_pkg::target_fb_type target_fb,
	output light_reg_pkg::phase_type phase
);
	import light_reg_pkg::*;

	logic [31:0] ctrl_r;
	logic [15:0] cfg_target_r;
	logic [15:0] target_r;
	logic [15:0] times_start_r;
	logic [15:0] times_down_r;
	logic [15:0] bus_bright_r;
	logic ext_presence_r;
	phase_type phase_r;
	phase_type phase_nxt;
	logic [15:0] wait_r;
	logic [TICK_CW-1:0] tick_cnt_r;
	logic tick;
	logic [7:0] level_r;
	logic fb_pending_r;
	logic aw_held_r;
	logic w_held_r;
	logic [5:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic [16:0] upper;
	dim_cmd_type dim_r;

	// Tick divider paces regulation and wait times
	// Limitation: waits are whole ticks and may end up to one tick late
	assign tick = (tick_cnt_r == TICK_CW'(TICK_CYCLES - 1));
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_r <= '0;
		end else begin
			tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
		end
	end

	// AXI write side: address and data taken independently
	wire do_write = aw_held_r && w_held_r && !s_axi_bvalid;
	wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
	wire wr_mapped = (awaddr_r[5:2] <= A_EVENT[5:2]) && (awaddr_r != A_STATUS) && (awaddr_r != A_BAND);
	assign s_axi_awready = !aw_held_r;
	assign s_axi_wready = !w_held_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				awaddr_r <= {s_axi_awaddr[5:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	wire wr_ctrl = do_write && (awaddr_r == A_CTRL);
	wire wr_tgt = do_write && (awaddr_r == A_TARGET);
	wire wr_ext = do_write && (awaddr_r == A_EXT_TGT);
	wire wr_event = do_write && (awaddr_r == A_EVENT);
	wire [31:0] wval = merge(32'h0000_0000, wdata_r, wmask);
	wire ev_restore = wr_event && wval[E_RESTORE];
	wire ev_download = wr_event && wval[E_DOWNLOAD];
	wire ev_bus_ret = wr_event && wval[E_BUS_RET];
	wire user_dyn = ctrl_r[C_USER_DYN];
	wire combined = ctrl_r[C_COMBINED] && ctrl_r[C_FB_ACTIVE];
	wire [15:0] ext_val = clamp_target(wdata_r[15:0], user_dyn);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= {8'h00, HYST_RST, 16'h0000};
			times_start_r <= '0;
			times_down_r <= '0;
			bus_bright_r <= '0;
			ext_presence_r <= 1'b0;
		end else begin
			if (wr_ctrl)
				ctrl_r <= merge(ctrl_r, wdata_r, wmask);
			if (do_write && awaddr_r == A_TIMES) begin
				times_start_r <= 16'(merge({16'h0000, times_start_r}, wdata_r, wmask));
				times_down_r <= 16'(merge({times_down_r, 16'h0000}, wdata_r, wmask) >> 16);
			end
			if (do_write && awaddr_r == A_BRIGHT)
				bus_bright_r <= wdata_r[15:0];
			if (wr_event)
				ext_presence_r <= wdata_r[E_PRESENCE];
		end
	end

	// Target store: default persists over bus loss, only explicit sources change it
	logic target_chg;
	assign target_chg = (wr_ext && ctrl_r[C_EXT_EN]) || ev_restore || (ev_download && ctrl_r[C_OVERWRITE]) || wr_tgt;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_target_r <= TARGET_RST;
			target_r <= TARGET_RST;
			fb_pending_r <= 1'b0;
		end else begin
			if (wr_tgt) begin
				cfg_target_r <= clamp_target(wdata_r[15:0], user_dyn);
				target_r <= clamp_target(wdata_r[15:0], user_dyn);
			end else if (wr_ext && ctrl_r[C_EXT_EN]) begin
				target_r <= ext_val;
			end else if (ev_restore || (ev_download && ctrl_r[C_OVERWRITE])) begin
				target_r <= cfg_target_r;
			end
			if (target_chg || ev_download || ev_bus_ret)
				fb_pending_r <= ctrl_r[C_FB_EN];
			else if (fb_pending_r && tick)
				fb_pending_r <= 1'b0;
		end
	end

	// One send per tick: a burst of target changes yields a single transmission
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			target_fb <= '0;
		end else begin
			target_fb.valid <= fb_pending_r && tick;
			target_fb.lux <= target_r;
		end
	end

	band_calc u_band (
		.target(target_r),
		.hyst_pct(ctrl_r[C_HYST_LSB +: 8]),
		.upper(upper)
	);

	// Presence and brightness source selection
	wire presence = combined ? fb1_presence : ext_presence_r;
	wire [15:0] bright = combined ? fb1_brightness : bus_bright_r;
	wire below = bright < target_r;
	wire above = 17'(bright) > upper;
	wire active = ctrl_r[C_ENABLE];
	wire wait_done = (wait_r == 16'h0000);

	// Startup gives up on lost presence rather than finishing its wait
	always_comb begin
		phase_nxt = phase_r;
		case (phase_r)
			PH_OFF: if (active && presence) phase_nxt = PH_START;
			PH_START: begin
				if (!presence)
					phase_nxt = PH_DOWN;
				else if (!below || (wait_done && tick))
					phase_nxt = PH_REG;
			end
			PH_REG: if (!presence || !active) phase_nxt = PH_DOWN;
			PH_DOWN: if (!ctrl_r[C_DIM_DOWN] || (wait_done && tick)) phase_nxt = PH_OFF;
			default: phase_nxt = PH_OFF;
		endcase
	end

	// Level mirrors the last command; saturates so steps never wrap
	wire entering = phase_nxt != phase_r;
	wire [7:0] lvl_up = (level_r > LEVEL_ON - LEVEL_STEP) ? LEVEL_ON : level_r + LEVEL_STEP;
	wire [7:0] lvl_dn = (level_r < LEVEL_STEP) ? LEVEL_OFF : level_r - LEVEL_STEP;
	wire adjust = tick && (phase_r == PH_REG) && !entering && (below || above);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_r <= PH_OFF;
			wait_r <= '0;
			level_r <= LEVEL_OFF;
			dim_r <= '0;
		end else begin
			phase_r <= phase_nxt;
			dim_r.valid <= 1'b0;
			dim_r.absolute <= ctrl_r[C_ABS];
			if (entering && phase_nxt == PH_START && below) begin
				wait_r <= times_start_r;
				level_r <= LEVEL_ON;
				dim_r.valid <= 1'b1;
				dim_r.step <= STEP_UP;
				dim_r.level <= LEVEL_ON;
			end else if (entering && phase_nxt == PH_DOWN) begin
				wait_r <= times_down_r;
				level_r <= ctrl_r[C_DIM_DOWN] ? LEVEL_MIN : LEVEL_OFF;
				dim_r.valid <= 1'b1;
				dim_r.step <= STEP_DOWN;
				dim_r.level <= ctrl_r[C_DIM_DOWN] ? LEVEL_MIN : LEVEL_OFF;
			end else if (entering && phase_nxt == PH_OFF) begin
				level_r <= LEVEL_OFF;
				dim_r.valid <= ctrl_r[C_DIM_DOWN];
				dim_r.step <= STEP_DOWN;
				dim_r.level <= LEVEL_OFF;
			end else if (adjust) begin
				level_r <= below ? lvl_up : lvl_dn;
				dim_r.valid <= 1'b1;
				dim_r.step <= below ? STEP_UP : STEP_DOWN;
				dim_r.level <= below ? lvl_up : lvl_dn;
			end else if (tick && !wait_done) begin
				wait_r <= wait_r - 1'b1;
			end
		end
	end

	assign dim_out = dim_r;
	assign phase = phase_r;

	// AXI read side
	// Read data latched at address accept so it stands until rready
	wire [31:0] rd_mux =
		(s_axi_araddr[5:2] == A_CTRL[5:2]) ? ctrl_r :
		(s_axi_araddr[5:2] == A_TARGET[5:2]) ? {16'h0000, cfg_target_r} :
		(s_axi_araddr[5:2] == A_EXT_TGT[5:2]) ? {16'h0000, target_r} :
		(s_axi_araddr[5:2] == A_TIMES[5:2]) ? {times_down_r, times_start_r} :
		(s_axi_araddr[5:2] == A_BRIGHT[5:2]) ? {16'h0000, bright} :
		(s_axi_araddr[5:2] == A_STATUS[5:2]) ? {20'h00000, level_r, presence, 1'b0, phase_r} :
		(s_axi_araddr[5:2] == A_BAND[5:2]) ? {15'h0000, upper} : 32'h0000_0000;
	wire rd_mapped = s_axi_araddr[5:2] <= A_EVENT[5:2];
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Sequencer and output checks
	off_to_start_a: assert property (phase_r == PH_OFF && active && presence |=> phase_r == PH_START)
		else $error("off did not enter startup");
	no_skip_a: assert property (phase_r == PH_OFF |=> phase_r inside {PH_OFF, PH_START})
		else $error("phase order broken");
	bright_start_a: assert property (phase_r == PH_START && presence && !below |=> phase_r == PH_REG)
		else $error("bright startup did not regulate");
	reg_to_down_a: assert property (phase_r == PH_REG && !presence |=> phase_r == PH_DOWN)
		else $error("lost presence kept regulating");
	start_abort_a: assert property (phase_r == PH_START && !presence |=> phase_r == PH_DOWN)
		else $error("startup not abandoned");
	in_band_a: assert property (phase_r == PH_REG && !below && !above && phase_nxt == PH_REG
		|=> !dim_r.valid)
		else $error("adjusted inside band");
	off_dark_a: assert property (phase_r == PH_OFF |-> level_r == LEVEL_OFF)
		else $error("light on while off");
	ext_target_a: assert property (wr_ext && ctrl_r[C_EXT_EN] |=> target_r == $past(ext_val))
		else $error("external target not adopted");
	restore_a: assert property (ev_restore && !wr_tgt && !(wr_ext && ctrl_r[C_EXT_EN])
		|=> target_r == cfg_target_r)
		else $error("restore failed");
	band_a: assert property (upper >= 17'(target_r))
		else $error("band upper below target");
	down_wait_a: assert property (phase_r == PH_DOWN && ctrl_r[C_DIM_DOWN] && !(wait_done && tick)
		|=> phase_r == PH_DOWN)
		else $error("dim-down left before its wait");
	start_dim_a: assert property (phase_r == PH_OFF && phase_nxt == PH_START && below
		|=> dim_r.valid && dim_r.level == LEVEL_ON)
		else $error("dark startup did not switch on");
	quiet_start_a: assert property (phase_r == PH_OFF && phase_nxt == PH_START && !below |=> !dim_r.valid)
		else $error("bright startup switched on");
	dim_form_a: assert property (dim_r.valid |-> dim_r.absolute == $past(ctrl_r[C_ABS]))
		else $error("dim command in wrong form");
	tgt_range_a: assert property (target_r >= LUX_USR_MIN && target_r <= LUX_USR_MAX)
		else $error("target outside range");
	fb_once_a: assert property (target_fb.valid |=> !target_fb.valid)
		else $error("feedback sent twice");
	disable_down_a: assert property (phase_r == PH_REG && !active |=> phase_r == PH_DOWN)
		else $error("disable kept regulating");

	startup_c: cover property (phase_r == PH_START ##1 phase_r == PH_REG);
	stepdown_c: cover property (phase_r == PH_REG ##1 phase_r == PH_DOWN);
	adjust_c: cover property (adjust);
	ext_c: cover property (wr_ext && ctrl_r[C_EXT_EN]);
	dimdown_c: cover property (phase_r == PH_DOWN && ctrl_r[C_DIM_DOWN]);
endmodule

// *** light_reg_pkg.sv ***
// Shared constants, types and register map for the constant-light regulator
package light_reg_pkg;
	localparam int unsigned CLK_HZ = 250_000_000;
	localparam int unsigned TICK_US = 1000;
	localparam int unsigned TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
	localparam int unsigned TICK_CW = 18;

	localparam logic [15:0] LUX_STD_MIN = 16'h0014;
	localparam logic [15:0] LUX_STD_MAX = 16'h03E8;
	localparam logic [15:0] LUX_USR_MIN = 16'h000A;
	localparam logic [15:0] LUX_USR_MAX = 16'h07D0;
	localparam logic [15:0] TARGET_RST = 16'h0190;
	localparam logic [7:0] HYST_RST = 8'h14;
	localparam logic [7:0] LEVEL_MIN = 8'h01;
	localparam logic [7:0] LEVEL_ON = 8'hFF;
	localparam logic [7:0] LEVEL_OFF = 8'h00;
	localparam logic [3:0] STEP_UP = 4'h9;
	localparam logic [3:0] STEP_DOWN = 4'h1;
	localparam logic [7:0] LEVEL_STEP = 8'h04;

	localparam logic [5:0] A_CTRL = 6'h00;
	localparam logic [5:0] A_TARGET = 6'h04;
	localparam logic [5:0] A_EXT_TGT = 6'h08;
	localparam logic [5:0] A_TIMES = 6'h0C;
	localparam logic [5:0] A_BRIGHT = 6'h10;
	localparam logic [5:0] A_STATUS = 6'h14;
	localparam logic [5:0] A_BAND = 6'h18;
	localparam logic [5:0] A_EVENT = 6'h1C;

	localparam int unsigned C_ENABLE = 0;
	localparam int unsigned C_COMBINED = 1;
	localparam int unsigned C_ABS = 2;
	localparam int unsigned C_DIM_DOWN = 3;
	localparam int unsigned C_USER_DYN = 4;
	localparam int unsigned C_FB_ACTIVE = 5;
	localparam int unsigned C_OVERWRITE = 6;
	localparam int unsigned C_EXT_EN = 7;
	localparam int unsigned C_FB_EN = 8;
	localparam int unsigned C_HYST_LSB = 16;
	localparam int unsigned E_PRESENCE = 0;
	localparam int unsigned E_RESTORE = 1;
	localparam int unsigned E_DOWNLOAD = 2;
	localparam int unsigned E_BUS_RET = 3;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		PH_OFF = 2'b00,
		PH_START = 2'b01,
		PH_REG = 2'b11,
		PH_DOWN = 2'b10
	} phase_type;

	typedef struct packed {
		logic valid;
		logic absolute;
		logic [3:0] step;
		logic [7:0] level;
	} dim_cmd_type;

	typedef struct packed {
		logic valid;
		logic [15:0] lux;
	} target_fb_type;

	function automatic logic [15:0] clamp_target(input logic [15:0] v, input logic user_dyn);
		logic [15:0] lo;
		logic [15:0] hi;
		lo = user_dyn ? LUX_USR_MIN : LUX_STD_MIN;
		hi = user_dyn ? LUX_USR_MAX : LUX_STD_MAX;
		clamp_target = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction
endpackage

// *** band_calc.sv ***
// Upper band limit from target and relative hysteresis
`timescale 1ns/1ps
module band_calc (
	input wire logic [15:0] target,
	input wire logic [7:0] hyst_pct,
	output logic [16:0] upper
);
	import light_reg_pkg::*;
	logic [23:0] prod;
	assign prod = 24'(target) * 24'(hyst_pct);
	// Divide by 100 via constant; truncation keeps the band at or above target
	assign upper = 17'(target) + 17'(prod / 24'h000064);
endmodule

// *** dimmer_room.sv ***
// Dimmer actuator and room light sensor on the far side of the regulator
`timescale 1ns/1ps
module dimmer_room (
	input wire logic clk,
	input wire logic rst_n,
	input wire light_reg_pkg::dim_cmd_type cmd,
	input wire logic [15:0] daylight,
	output logic [15:0] lux
);
	import light_reg_pkg::*;
	logic [7:0] level_r;
	logic [8:0] up_nxt;
	assign up_nxt = {1'b0, level_r} + {1'b0, LEVEL_STEP};
	// Sensor sees daylight plus two lux per level count, eight per LEVEL_STEP
	assign lux = daylight + {7'h00, level_r, 1'b0};
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level_r <= LEVEL_OFF;
		end else if (cmd.valid && cmd.absolute) begin
			level_r <= cmd.level;
		end else if (cmd.valid && cmd.step[3] && cmd.step[2:0] != 3'h0) begin
			level_r <= up_nxt[8] ? 8'hFF : up_nxt[7:0];
		end else if (cmd.valid && cmd.step[2:0] != 3'h0) begin
			// Saturate at off rather than wrap to full brightness
			level_r <= (level_r < LEVEL_STEP) ? LEVEL_OFF : level_r - LEVEL_STEP;
		end
	end
endmodule

// *** tb_light_reg.sv ***
// Self-checking bench for the constant-light regulator
`timescale 1ns/1ps
module tb_light_reg;
	import light_reg_pkg::*;
	typedef struct packed {
		logic [31:0] data;
		logic [1:0] resp;
	} rd_exp_type;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [5:0] awaddr = 6'h00;
	logic awvalid = 1'b0;
	logic awready;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic wvalid = 1'b0;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready = 1'b0;
	logic [5:0] araddr = 6'h00;
	logic arvalid = 1'b0;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready = 1'b0;
	logic fb1_presence = 1'b0;
	logic [15:0] room_lux;
	logic [15:0] daylight = 16'h0000;
	dim_cmd_type dim_out;
	target_fb_type tfb;
	phase_type phase;
	logic [1:0] bq[$];
	rd_exp_type rq[$];
	dim_cmd_type dq[$];
	rd_exp_type re;
	dim_cmd_type de;
	logic [15:0] t;
	logic [15:0] lim;
	int fail_count = 0;
	int check_count = 0;

	always #2 clk = ~clk;

	light_reg i_dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fb1_presence(fb1_presence),
		.fb1_brightness(room_lux), .dim_out(dim_out), .target_fb(tfb), .phase(phase));
	dimmer_room i_room (.clk(clk), .rst_n(rst_n), .cmd(dim_out), .daylight(daylight), .lux(room_lux));

	task automatic chk(input bit ok, input string m);
		check_count++;
		if (!ok) begin
			fail_count++;
			$display("BAD %0t %s", $time, m);
		end
	endtask

	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Both channels offered together, each dropped once taken
	task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		bq.push_back(er);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				bready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic rd(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		rq.push_back('{d, er});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				rready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic exp_dim(input logic ab, input logic [3:0] st, input logic [7:0] lv);
		dq.push_back('{1'b1, ab, st, lv});
	endtask

	task automatic wait_ph(input phase_type p);
		int n;
		n = 0;
		while (phase !== p && n < 1000) begin
			@(posedge clk);
			n++;
		end
		chk(phase === p, "phase not reached");
	endtask

	always @(posedge clk) begin
		if (bvalid && bready) begin
			if (bq.size() == 0) chk(1'b0, "stray write response");
			else chk(bresp === bq.pop_front(), "write response");
		end
		if (rvalid && rready) begin
			if (rq.size() == 0) chk(1'b0, "stray read");
			else begin
				re = rq.pop_front();
				chk(rdata === re.data && rresp === re.resp, "read data");
			end
		end
		if (dim_out.valid === 1'b1) begin
			if (dq.size() == 0) chk(1'b0, "unexpected dim command");
			else begin
				de = dq.pop_front();
				// Only the field that the chosen form carries is meaningful
				chk(dim_out.absolute === de.absolute && (de.absolute ? dim_out.level === de.level :
					dim_out.step === de.step), "dim command");
			end
		end
	end

	initial begin
		#400000;
		fail_count++;
		$display("BAD %0t watchdog expired", $time);
		end_sim();
	end

	initial begin
		void'($urandom(32'hD3F9));
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rd(A_TARGET, 32'h0000_0190, RESP_OKAY);
		rd(A_BAND, 32'h0000_01E0, RESP_OKAY);
		rd(6'h20, 32'h0000_0000, RESP_SLVERR);
		wr(A_STATUS, 32'h0000_0001, RESP_SLVERR);
		rd(A_STATUS, 32'h0000_0000, RESP_OKAY);
		for (int i = 0; i < 4; i++) begin
			wr(A_CTRL, {16'h0014, 11'h000, i[1], 4'h0}, RESP_OKAY);
			wr(A_TARGET, i[0] ? 32'h0000_0BB8 : 32'h0000_0005, RESP_OKAY);
			lim = i[1] ? (i[0] ? LUX_USR_MAX : LUX_USR_MIN) : (i[0] ? LUX_STD_MAX : LUX_STD_MIN);
			rd(A_TARGET, {16'h0000, lim}, RESP_OKAY);
			rd(A_BAND, {16'h0000, lim + lim / 16'h0005}, RESP_OKAY);
		end
		wr(A_CTRL, 32'h0014_0085, RESP_OKAY);
		wr(A_TARGET, 32'h0000_0190, RESP_OKAY);
		wr(A_TIMES, 32'h0001_0064, RESP_OKAY);
		wr(A_BRIGHT, 32'h0000_0064, RESP_OKAY);
		exp_dim(1'b1, 4'h0, LEVEL_ON);
		wr(A_EVENT, 32'h0000_0001, RESP_OKAY);
		wait_ph(PH_START);
		exp_dim(1'b1, 4'h0, LEVEL_OFF);
		wr(A_EVENT, 32'h0000_0000, RESP_OKAY);
		wait_ph(PH_OFF);
		wr(A_BRIGHT, 32'h0000_01C2, RESP_OKAY);
		wr(A_EVENT, 32'h0000_0001, RESP_OKAY);
		wait_ph(PH_REG);
		t = 16'($urandom_range(LUX_STD_MAX, LUX_STD_MIN));
		wr(A_EXT_TGT, {16'h0000, t}, RESP_OKAY);
		rd(A_EXT_TGT, {16'h0000, t}, RESP_OKAY);
		chk(tfb.lux === t, "target feedback value");
		rd(A_BAND, {16'h0000, t + t / 16'h0005}, RESP_OKAY);
		wr(A_EVENT, 32'h0000_0009, RESP_OKAY);
		wr(A_EVENT, 32'h0000_0005, RESP_OKAY);
		rd(A_EXT_TGT, {16'h0000, t}, RESP_OKAY);
		wr(A_EVENT, 32'h0000_0003, RESP_OKAY);
		rd(A_EXT_TGT, 32'h0000_0190, RESP_OKAY);
		chk(tfb.lux === TARGET_RST, "restored feedback value");
		wr(A_EXT_TGT, {16'h0000, t}, RESP_OKAY);
		wr(A_CTRL, 32'h0014_00C5, RESP_OKAY);
		wr(A_EVENT, 32'h0000_0005, RESP_OKAY);
		rd(A_EXT_TGT, 32'h0000_0190, RESP_OKAY);
		exp_dim(1'b1, 4'h0, LEVEL_OFF);
		wr(A_EVENT, 32'h0000_0000, RESP_OKAY);
		wait_ph(PH_OFF);
		wr(A_CTRL, 32'h0014_002B, RESP_OKAY);
		wr(A_EVENT, 32'h0000_0001, RESP_OKAY);
		repeat (20) @(posedge clk);
		chk(phase === PH_OFF, "external presence taken in combined mode");
		t = 16'($urandom_range(32'h0000_00C8, 32'h0000_0000));
		daylight <= t;
		rd(A_BRIGHT, {16'h0000, t}, RESP_OKAY);
		exp_dim(1'b0, STEP_UP, 8'h00);
		fb1_presence <= 1'b1;
		wait_ph(PH_START);
		exp_dim(1'b0, STEP_DOWN, 8'h00);
		fb1_presence <= 1'b0;
		wait_ph(PH_DOWN);
		repeat (20) @(posedge clk);
		chk(phase === PH_DOWN, "dim-down did not wait");
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		chk(phase === PH_OFF, "phase during reset");
		rst_n <= 1'b1;
		rd(A_TARGET, 32'h0000_0190, RESP_OKAY);
		chk(dq.size() == 0, "dim command missing");
		end_sim();
	end
endmodule
